// >>> core/idt_decode_core.sv
// instruction decode and cycle timing for the 16-bit core
`timescale 1ns/1ns
`include "idt_regs.svh"
module idt_decode_core (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [23:0] fetchWord,
    input wire logic fetchValid,
    input wire logic condTrue,
    output logic fetchReady_r,
    output logic instrValid_r,
    output logic nopSlot_r,
    output logic [7:0] opcode_r,
    output idt_pkg::idt_class_e opClass_r,
    output logic [3:0] baseReg_r,
    output logic [3:0] srcReg_r,
    output logic [1:0] srcMode_r,
    output logic [3:0] destReg_r,
    output logic [1:0] destMode_r,
    output logic [12:0] fileAddr_r,
    output logic toFile_r,
    output logic [3:0] bitSel_r,
    output logic bitIndirect_r,
    output logic [22:0] literal_r,
    output idt_pkg::idt_flags_t flagMask_r,
    output logic [4:0] cycles_r,
    output logic [1:0] variant_r,
    output logic wdtRestart_r,
    output logic wordTwoBad_r,
    output logic irqBlocked
);
    idt_pkg::idt_state_e state_r, state_nxt;
    idt_pkg::idt_class_e cls;
    idt_pkg::idt_flags_t clsFlags;
    logic clsTwo, accept, flushNow, flushSkip, issueOne, issueTwo, loadExtra;
    logic skipPend_r, pendSkip_r, condInstr_r, condSkip_r, extraBusy;
    logic [4:0] clsCycles, extraVal, extraCount;
    logic [7:0] opc;

    assign opc = fetchWord[`IDT_OPC_LSB +: `IDT_OPC_W];

    idt_op_class u_class (
        .opcode(opc),
        .opClass(cls),
        .twoWord(clsTwo),
        .cycles(clsCycles),
        .flagMask(clsFlags)
    );

    idt_down_counter #(.W(5)) u_extra (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .load(loadExtra),
        .loadVal(extraVal),
        .count_r(extraCount),
        .busy_r(extraBusy)
    );

    // interrupt hold counts instruction cycles, not fetches
    idt_down_counter #(.W(`IDT_HOLD_W)) u_hold (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .load(issueOne && cls == idt_pkg::CLS_HOLD),
        .loadVal(fetchWord[`IDT_HOLD_W-1:0]),
        .count_r(),
        .busy_r(irqBlocked)
    );

    // accept, flush and issue decisions for the word on the fetch port
    always_comb begin
        accept = clkEn && fetchValid && fetchReady_r;
        flushNow = skipPend_r || (instrValid_r && condInstr_r && condTrue);
        flushSkip = skipPend_r ? pendSkip_r : condSkip_r;
        issueOne = accept && state_r == idt_pkg::ST_FETCH && !flushNow && !clsTwo;
        issueTwo = accept && state_r == idt_pkg::ST_WORD2;
        extraVal = issueTwo ? cycles_r - `IDT_CYC_TWO : clsCycles - `IDT_CYC_ONE;
        loadExtra = (issueOne || issueTwo) && extraVal != 5'h00;
    end

    // sequencing; the extra cycles hold fetch off and run as no-ops
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            idt_pkg::ST_FETCH: begin
                if (accept && flushNow) begin
                    // a skipped two-word form drops its second word too
                    if (flushSkip && clsTwo) begin
                        state_nxt = idt_pkg::ST_SKIP2;
                    end
                end else if (accept && clsTwo) begin
                    state_nxt = idt_pkg::ST_WORD2;
                end else if (loadExtra) begin
                    state_nxt = idt_pkg::ST_EXTRA;
                end
            end
            idt_pkg::ST_WORD2: begin
                if (issueTwo) begin
                    state_nxt = loadExtra ? idt_pkg::ST_EXTRA : idt_pkg::ST_FETCH;
                end
            end
            idt_pkg::ST_EXTRA: begin
                if (extraCount == 5'h01 || !extraBusy) begin
                    state_nxt = idt_pkg::ST_FETCH;
                end
            end
            idt_pkg::ST_SKIP2: begin
                if (accept) begin
                    state_nxt = idt_pkg::ST_FETCH;
                end
            end
            default: state_nxt = idt_pkg::ST_FETCH;
        endcase
    end

    // state and fetch handshake
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= idt_pkg::ST_FETCH;
            fetchReady_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            fetchReady_r <= (state_nxt != idt_pkg::ST_EXTRA);
        end
    end

    // a taken condition with no word yet waiting is remembered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            skipPend_r <= 1'b0;
            pendSkip_r <= 1'b0;
        end else if (clkEn) begin
            if (accept) begin
                skipPend_r <= 1'b0;
            end else if (flushNow) begin
                skipPend_r <= 1'b1;
                pendSkip_r <= flushSkip;
            end
        end
    end

    // operand fields, captured from the first word of every instruction
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            opcode_r <= 8'h00;
            opClass_r <= idt_pkg::CLS_NOP;
            baseReg_r <= 4'h0;
            srcReg_r <= 4'h0;
            srcMode_r <= 2'h0;
            destReg_r <= 4'h0;
            destMode_r <= 2'h0;
            fileAddr_r <= 13'h0000;
            toFile_r <= 1'b0;
            bitSel_r <= 4'h0;
            bitIndirect_r <= 1'b0;
            flagMask_r <= `IDT_FLG_NONE;
            cycles_r <= `IDT_CYC_ONE;
            variant_r <= 2'h0;
            condInstr_r <= 1'b0;
            condSkip_r <= 1'b0;
        end else if (clkEn && accept && state_r == idt_pkg::ST_FETCH && !flushNow) begin
            opcode_r <= opc;
            opClass_r <= cls; // lone second word has opcode zero: no-op
            baseReg_r <= fetchWord[`IDT_BASE_LSB +: 4];
            srcReg_r <= fetchWord[`IDT_SRC_LSB +: 4];
            srcMode_r <= fetchWord[`IDT_SMODE_LSB +: 2];
            destMode_r <= fetchWord[`IDT_DMODE_LSB +: 2];
            // literal forms only carry a destination when it differs
            if (cls == idt_pkg::CLS_LIT) begin
                destReg_r <= fetchWord[`IDT_LDST_BIT] ? fetchWord[`IDT_LDEST_LSB +: 4]
                                                      : fetchWord[`IDT_BASE_LSB +: 4];
            end else begin
                destReg_r <= fetchWord[`IDT_DEST_LSB +: 4];
            end
            fileAddr_r <= fetchWord[`IDT_FADDR_W-1:0];
            // file destination: the register itself or w0
            toFile_r <= (cls == idt_pkg::CLS_BIT || cls == idt_pkg::CLS_BITTEST ||
                         cls == idt_pkg::CLS_BTSS) ? fetchWord[`IDT_BFILE_BIT]
                                                   : fetchWord[`IDT_FDST_BIT];
            bitSel_r <= fetchWord[`IDT_BLIT_LSB +: 4];
            bitIndirect_r <= fetchWord[`IDT_BIND_BIT];
            flagMask_r <= clsFlags;
            cycles_r <= clsCycles;
            // borrow, scan side, signedness, skip condition, test target
            variant_r <= opc[1:0];
            condInstr_r <= (cls == idt_pkg::CLS_CPSKIP || cls == idt_pkg::CLS_BTSS ||
                            cls == idt_pkg::CLS_CONDBR);
            condSkip_r <= (cls == idt_pkg::CLS_CPSKIP || cls == idt_pkg::CLS_BTSS);
        end
    end

    // literal assembly; a two-word form completes from its second word
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            literal_r <= 23'h000000;
            wordTwoBad_r <= 1'b0;
        end else if (clkEn) begin
            wordTwoBad_r <= 1'b0;
            if (issueTwo) begin
                literal_r <= {fetchWord[`IDT_W2LO_W-1:0], literal_r[15:0]};
                wordTwoBad_r <= (opc != 8'h00); // upper byte must be zero
            end else if (accept && state_r == idt_pkg::ST_FETCH && !flushNow) begin
                if (cls == idt_pkg::CLS_HOLD) begin
                    literal_r <= {9'h000, fetchWord[`IDT_HOLD_W-1:0]};
                end else if (cls == idt_pkg::CLS_LIT) begin
                    literal_r <= {16'h0000, fetchWord[`IDT_LIT_W-1:0]};
                end else begin
                    literal_r <= {7'h00, fetchWord[15:0]};
                end
            end
        end
    end

    // one-cycle strobes: issue, no-op slot, watchdog restart
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            instrValid_r <= 1'b0;
            nopSlot_r <= 1'b0;
            wdtRestart_r <= 1'b0;
        end else if (clkEn) begin
            instrValid_r <= issueOne || issueTwo;
            // flushed words and extra cycles show as no-ops
            nopSlot_r <= (accept && flushNow) || (accept && state_r == idt_pkg::ST_SKIP2) ||
                         state_r == idt_pkg::ST_EXTRA;
            wdtRestart_r <= issueOne && cls == idt_pkg::CLS_WDT;
        end
    end

    // checks, counted in enabled cycles only
    default clocking cb @(posedge mclk iff clkEn); endclocking
    default disable iff (!rst_b);

    div_eighteen_cyc_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_DIV |-> !fetchReady_r ##17 fetchReady_r)
        else $error("divide did not take eighteen cycles");
    return_three_cyc_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_RETURN |-> !fetchReady_r ##2 fetchReady_r)
        else $error("return did not take three cycles");
    branch_two_cyc_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_BRANCH |-> !fetchReady_r ##1 fetchReady_r)
        else $error("branch did not take two cycles");
    single_cyc_ready_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_FILE |-> fetchReady_r)
        else $error("single-cycle instruction stalled fetch");
    word_two_zero_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_TWOWORD
        |-> wordTwoBad_r == ($past(fetchWord[23:16]) != 8'h00))
        else $error("second word upper byte check wrong");
    lone_word_nop_a: assert property (
        instrValid_r && opcode_r == 8'h00 |-> opClass_r == idt_pkg::CLS_NOP &&
        flagMask_r == `IDT_FLG_NONE && fetchReady_r)
        else $error("zero opcode not a plain no-op");
    skip_flush_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_CPSKIP && condTrue && fetchValid &&
        fetchReady_r |=> nopSlot_r && !instrValid_r)
        else $error("taken skip did not drop next word");
    hold_blocks_irq_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_HOLD && literal_r != 23'h000000
        |-> irqBlocked)
        else $error("interrupt hold not active");
    div_flags_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_DIV |-> flagMask_r == `IDT_FLG_DIV)
        else $error("divide flag set wrong");
    cmp_flags_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_CMP |-> flagMask_r == `IDT_FLG_ARITH)
        else $error("compare flag set wrong");
    wdt_restart_a: assert property (
        wdtRestart_r |-> instrValid_r && flagMask_r == `IDT_FLG_WDT)
        else $error("watchdog restart without its instruction");
    skip_two_word_a: assert property (
        state_r == idt_pkg::ST_SKIP2 && accept |=> nopSlot_r && !instrValid_r)
        else $error("second word of skipped form was issued");
    condbr_drop_a: assert property (
        instrValid_r && opClass_r == idt_pkg::CLS_CONDBR && condTrue && fetchValid &&
        fetchReady_r |=> nopSlot_r && !instrValid_r)
        else $error("taken branch did not drop next word");

    div_seen_c: cover property (instrValid_r && opClass_r == idt_pkg::CLS_DIV);
    skip_two_word_c: cover property (state_r == idt_pkg::ST_SKIP2);
    call_direct_c: cover property (instrValid_r && opClass_r == idt_pkg::CLS_TWOWORD);
    hold_active_c: cover property (irqBlocked);
endmodule

// >>> core/idt_down_counter.sv
// loadable down counter with a registered busy flag
`timescale 1ns/1ns
module idt_down_counter #(
    parameter int W = 5
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [W-1:0] loadVal,
    output logic [W-1:0] count_r,
    output logic busy_r
);
    // busy is registered so callers may drive outputs straight from it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
            busy_r <= 1'b0;
        end else if (clkEn) begin
            if (load) begin
                count_r <= loadVal;
                busy_r <= (loadVal != '0);
            end else if (count_r != '0) begin
                count_r <= count_r - 1'b1;
                busy_r <= (count_r > 1);
            end
        end
    end
endmodule

// >>> core/idt_op_class.sv
// opcode classifier: class, word count, cycle count and flags touched
`timescale 1ns/1ns
`include "idt_regs.svh"
module idt_op_class (
    input wire logic [7:0] opcode,
    output idt_pkg::idt_class_e opClass,
    output logic twoWord,
    output logic [4:0] cycles,
    output idt_pkg::idt_flags_t flagMask
);
    // unlisted opcodes fall to one cycle and no flags
    always_comb begin
        opClass = idt_pkg::CLS_NOP;
        twoWord = 1'b0;
        cycles = `IDT_CYC_ONE;
        flagMask = `IDT_FLG_NONE;
        casez (opcode)
            `IDT_OP_CALL2, `IDT_OP_GOTO2, `IDT_OP_MOVLIT2: begin
                opClass = idt_pkg::CLS_TWOWORD; // only three two-word forms
                twoWord = 1'b1;
                cycles = `IDT_CYC_TWO;
            end
            `IDT_OP_CALLIND, `IDT_OP_GOTOIND: begin
                opClass = idt_pkg::CLS_CALLIND;
                cycles = `IDT_CYC_TWO;
            end
            `IDT_OP_RETURN, `IDT_OP_RETIRQ: begin
                opClass = idt_pkg::CLS_RETURN;
                cycles = `IDT_CYC_RET;
            end
            `IDT_OP_BRANCH: begin
                opClass = idt_pkg::CLS_BRANCH;
                cycles = `IDT_CYC_TWO;
            end
            `IDT_OP_TBLRD, `IDT_OP_TBLWT: begin
                opClass = idt_pkg::CLS_TABLE;
                cycles = `IDT_CYC_TWO;
            end
            `IDT_OP_MOVD: begin
                opClass = idt_pkg::CLS_MOVD;
                cycles = `IDT_CYC_TWO;
            end
            `IDT_OP_CONDBR: opClass = idt_pkg::CLS_CONDBR;
            `IDT_OP_REGOP: opClass = idt_pkg::CLS_REGOP;
            `IDT_OP_LIT: begin
                opClass = idt_pkg::CLS_LIT;
                flagMask = `IDT_FLG_ARITH;
            end
            `IDT_OP_FILE: opClass = idt_pkg::CLS_FILE;
            `IDT_OP_BITTEST: begin
                opClass = idt_pkg::CLS_BITTEST;
                flagMask = opcode[0] ? `IDT_FLG_Z : `IDT_FLG_C;
            end
            `IDT_OP_BTSS: opClass = idt_pkg::CLS_BTSS;
            `IDT_OP_BIT: opClass = idt_pkg::CLS_BIT;
            `IDT_OP_FF1TOP, `IDT_OP_FF1BOT: begin
                opClass = idt_pkg::CLS_FF1;
                flagMask = `IDT_FLG_C;
            end
            `IDT_OP_DIV: begin
                opClass = idt_pkg::CLS_DIV;
                cycles = `IDT_CYC_DIV;
                flagMask = `IDT_FLG_DIV;
            end
            `IDT_OP_CMP: begin
                opClass = idt_pkg::CLS_CMP;
                flagMask = `IDT_FLG_ARITH;
            end
            `IDT_OP_CPSKIP: opClass = idt_pkg::CLS_CPSKIP; // no flags
            `IDT_OP_DECTWO: begin
                opClass = idt_pkg::CLS_DECTWO;
                flagMask = `IDT_FLG_ARITH;
            end
            `IDT_OP_HOLD: opClass = idt_pkg::CLS_HOLD; // one cycle, no flags
            `IDT_OP_WDT: begin
                opClass = idt_pkg::CLS_WDT;
                flagMask = `IDT_FLG_WDT;
            end
            default: opClass = idt_pkg::CLS_NOP;
        endcase
    end
endmodule

// >>> core/idt_pkg.sv
// types shared by the decoder modules
package idt_pkg;
    typedef enum logic [4:0] {
        CLS_NOP, CLS_FILE, CLS_REGOP, CLS_BIT, CLS_BITTEST, CLS_BTSS, CLS_LIT, CLS_CMP,
        CLS_CPSKIP, CLS_BRANCH, CLS_CONDBR, CLS_CALLIND, CLS_TABLE, CLS_RETURN,
        CLS_DIV, CLS_HOLD, CLS_WDT, CLS_FF1, CLS_DECTWO, CLS_MOVD, CLS_TWOWORD
    } idt_class_e;
    typedef enum logic [1:0] {
        ST_FETCH = 2'h0,
        ST_WORD2 = 2'h1,
        ST_EXTRA = 2'h3,
        ST_SKIP2 = 2'h2
    } idt_state_e;
    typedef logic [6:0] idt_flags_t;
endpackage

// >>> core/idt_regs.svh
// opcode map, field positions, cycle counts and flag masks of the decoder
`ifndef IDT_REGS_SVH
`define IDT_REGS_SVH
`define IDT_WORD_W 24
`define IDT_OPC_LSB 16
`define IDT_OPC_W 8
`define IDT_BASE_LSB 12
`define IDT_DMODE_LSB 10
`define IDT_DEST_LSB 6
`define IDT_SMODE_LSB 4
`define IDT_SRC_LSB 0
`define IDT_FDST_BIT 13
`define IDT_FADDR_W 13
`define IDT_BLIT_LSB 12
`define IDT_BIND_BIT 11
`define IDT_BFILE_BIT 10
`define IDT_BBASE_LSB 6
`define IDT_LDST_BIT 11
`define IDT_LDEST_LSB 7
`define IDT_LIT_W 7
`define IDT_HOLD_W 14
`define IDT_W2LO_W 7
`define IDT_OP_NOP 8'h00
`define IDT_OP_CALLIND 8'h01
`define IDT_OP_CALL2 8'h02
`define IDT_OP_GOTO2 8'h04
`define IDT_OP_GOTOIND 8'h05
`define IDT_OP_MOVLIT2 8'h06
`define IDT_OP_RETURN 8'h08
`define IDT_OP_RETIRQ 8'h09
`define IDT_OP_CONDBR 8'h31
`define IDT_OP_BRANCH 8'h37
`define IDT_OP_REGOP 8'h4?
`define IDT_OP_LIT 8'h5?
`define IDT_OP_FILE 8'h8?
`define IDT_OP_BITTEST 8'hA0,8'hA1,8'hA2,8'hA3
`define IDT_OP_BTSS 8'hA4
`define IDT_OP_BIT 8'hA8
`define IDT_OP_TBLRD 8'hBA
`define IDT_OP_TBLWT 8'hBB
`define IDT_OP_MOVD 8'hBE
`define IDT_OP_FF1TOP 8'hCE
`define IDT_OP_FF1BOT 8'hCF
`define IDT_OP_DIV 8'hD8,8'hD9,8'hDA,8'hDB
`define IDT_OP_CMP 8'hE0,8'hE1,8'hE2,8'hE3
`define IDT_OP_CPSKIP 8'hE4,8'hE5,8'hE6,8'hE7
`define IDT_OP_DECTWO 8'hEC,8'hED
`define IDT_OP_HOLD 8'hFC
`define IDT_OP_WDT 8'hFE
`define IDT_CYC_ONE 5'h01
`define IDT_CYC_TWO 5'h02
`define IDT_CYC_RET 5'h03
`define IDT_CYC_DIV 5'h12
`define IDT_FLG_NONE 7'h00
`define IDT_FLG_C 7'h01
`define IDT_FLG_Z 7'h10
`define IDT_FLG_NZ 7'h14
`define IDT_FLG_ARITH 7'h1F
`define IDT_FLG_DIV 7'h1D
`define IDT_FLG_WDT 7'h60
`endif

// >>> tb/idt_prog_mem.sv
// program memory model that feeds words to the decoder's fetch port
`timescale 1ns/1ns
module idt_prog_mem (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic run,
    input wire logic slow,
    input wire logic [4:0] progLen,
    input wire logic ready,
    output logic [23:0] fetchWord,
    output logic fetchValid,
    output logic [4:0] taken_r
);
    logic [23:0] mem [16];
    logic [23:0] last_r;
    logic gap_r;

    // a slow memory leaves a gap every other cycle
    assign fetchValid = run && (taken_r < progLen) && !(slow && gap_r);
    // idle bus shows the inverse of the last word, so stale data never looks valid
    assign fetchWord = fetchValid ? mem[taken_r[3:0]] : ~last_r;

    // word pointer; a word is held until the decoder takes it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            taken_r <= 5'h00;
            gap_r <= 1'b0;
            last_r <= 24'h000000;
        end else if (!run) begin
            taken_r <= 5'h00;
            gap_r <= 1'b0;
        end else if (clkEn) begin
            gap_r <= !gap_r;
            if (fetchValid && ready) begin
                taken_r <= taken_r + 5'h01;
                last_r <= fetchWord;
            end
        end
    end
endmodule

// >>> tb/test_idt_decode_core.sv
// self-checking bench for the decode and timing core
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_idt_decode_core;
    logic mclk = 0, rst_b = 0, clkEn = 1, condTrue = 0, run = 0, slow = 0;
    logic [4:0] progLen = 5'h00, cycles_r, taken;
    logic [23:0] fetchWord;
    logic fetchValid, fetchReady_r, instrValid_r, nopSlot_r, toFile_r, bitIndirect_r;
    logic wdtRestart_r, wordTwoBad_r, irqBlocked;
    logic [7:0] opcode_r;
    idt_pkg::idt_class_e opClass_r;
    logic [3:0] baseReg_r, srcReg_r, destReg_r, bitSel_r;
    logic [1:0] srcMode_r, destMode_r, variant_r;
    logic [12:0] fileAddr_r;
    logic [22:0] literal_r;
    idt_pkg::idt_flags_t flagMask_r;
    int fails = 0, checks_done = 0, ticks = 0, issues, nops, lows, wdts, bads, irqs;
    // opcode, flags touched, nominal cycles, cycles refused after issue
    logic [31:0] tbl [32] = '{32'hD81D1211, 32'hD91D1211, 32'hDA1D1211, 32'hDB1D1211,
        32'hE01F0100, 32'hE11F0100, 32'hE21F0100, 32'hE31F0100, 32'hEC1F0100,
        32'hED1F0100, 32'hCE010100, 32'hCF010100, 32'hA0010100, 32'hA1100100,
        32'hA2010100, 32'hA3100100, 32'hA4000100, 32'hFE600100, 32'hFC000100,
        32'hE4000100, 32'hE5000100, 32'hE6000100, 32'hE7000100, 32'h00000100,
        32'h37000201, 32'hBA000201, 32'hBB000201, 32'h01000201, 32'h05000201,
        32'h08000302, 32'h09000302, 32'hBE000201};

    always #25 mclk = ~mclk;

    idt_decode_core uut (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .fetchWord(fetchWord),
        .fetchValid(fetchValid), .condTrue(condTrue), .fetchReady_r(fetchReady_r),
        .instrValid_r(instrValid_r), .nopSlot_r(nopSlot_r), .opcode_r(opcode_r),
        .opClass_r(opClass_r), .baseReg_r(baseReg_r), .srcReg_r(srcReg_r),
        .srcMode_r(srcMode_r), .destReg_r(destReg_r), .destMode_r(destMode_r),
        .fileAddr_r(fileAddr_r), .toFile_r(toFile_r), .bitSel_r(bitSel_r),
        .bitIndirect_r(bitIndirect_r), .literal_r(literal_r), .flagMask_r(flagMask_r),
        .cycles_r(cycles_r), .variant_r(variant_r), .wdtRestart_r(wdtRestart_r),
        .wordTwoBad_r(wordTwoBad_r), .irqBlocked(irqBlocked));
    idt_prog_mem pm (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .run(run), .slow(slow),
        .progLen(progLen), .ready(fetchReady_r), .fetchWord(fetchWord),
        .fetchValid(fetchValid), .taken_r(taken));

    // tally port activity in enabled cycles; a frozen cycle counts for nothing
    always @(posedge mclk) begin
        ticks++;
        if (run && clkEn) begin
            issues += int'(instrValid_r === 1'b1);
            nops += int'(nopSlot_r === 1'b1);
            lows += int'(fetchReady_r === 1'b0);
            wdts += int'(wdtRestart_r === 1'b1);
            bads += int'(wordTwoBad_r === 1'b1);
            irqs += int'(irqBlocked === 1'b1);
        end
        // limit reached: count it and go to the closing report
        if (ticks == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // runs n words; settle time covers the longest stall plus a short freeze
    task automatic run_prog(input int n);
        int k;
        @(posedge mclk);
        #5;
        {issues, nops, lows, wdts, bads, irqs} = 192'h0;
        progLen = n[4:0];
        run = 1;
        for (k = 0; k < 100 && taken != n[4:0]; k++) @(posedge mclk);
        repeat (24) @(posedge mclk);
        #5;
        run = 0;
        @(posedge mclk);
        #5;
    endtask

    task automatic one(input logic [23:0] w);
        pm.mem[0] = w;
        run_prog(1);
    endtask

    task automatic t_fields;
        one(24'h41A5B3);
        `CHK(opcode_r, 8'h41)
        `CHK(issues, 1)
        `CHK({baseReg_r, srcReg_r, srcMode_r}, 10'h28F)
        `CHK({destReg_r, destMode_r}, 6'h19)
        one(24'h803DBC);
        `CHK({toFile_r, fileAddr_r}, 14'h3DBC)
        one(24'h800123);
        `CHK({toFile_r, fileAddr_r}, 14'h0123)
        one(24'hA8CC00);
        `CHK({bitSel_r, bitIndirect_r, toFile_r}, 6'h33)
        one(24'h507C85);
        `CHK({destReg_r, literal_r}, 27'h4800005)
        one(24'h503312);
        `CHK(destReg_r, 4'h3)
    endtask

    task automatic t_table;
        for (int i = 0; i < 32; i++) begin
            one({tbl[i][31:24], 16'h0001});
            `CHK(flagMask_r, tbl[i][22:16])
            `CHK(cycles_r, tbl[i][12:8])
            `CHK(lows, int'(tbl[i][7:0]))
            `CHK(variant_r, tbl[i][25:24])
            `CHK(wdts, int'(tbl[i][31:24] == 8'hFE))
            `CHK(issues, 1)
        end
    endtask

    // a stall that spans a clock-enable freeze must still last its full count
    task automatic t_freeze;
        pm.mem[0] = 24'hDA0001;
        fork
            run_prog(1);
            begin
                repeat (6) @(posedge mclk);
                #5;
                clkEn = 0;
                repeat (3) @(posedge mclk);
                #5;
                clkEn = 1;
            end
        join
        `CHK(lows, 17)
        `CHK(issues, 1)
    endtask

    task automatic t_hold;
        one(24'hFCC005);
        `CHK(irqs, 5)
        `CHK(literal_r, 23'h000005)
    endtask

    task automatic t_twoword;
        pm.mem[0] = 24'h021234;
        pm.mem[1] = 24'h000055;
        slow = 1;
        run_prog(2);
        `CHK(literal_r, 23'h551234)
        `CHK(issues, 1)
        `CHK(bads, 0)
        `CHK(cycles_r, 5'h02)
        pm.mem[0] = 24'h04ABCD;
        pm.mem[1] = 24'h05007F;
        pm.mem[2] = 24'h060001;
        pm.mem[3] = 24'h000002;
        run_prog(4);
        slow = 0;
        `CHK(issues, 2)
        `CHK(bads, 1)
        `CHK(literal_r, 23'h020001)
        one(24'h000042);
        `CHK(opClass_r, idt_pkg::CLS_NOP)
        `CHK(flagMask_r, 7'h00)
    endtask

    // taken skips over one- and two-word forms, then a taken branch and a bit skip
    task automatic t_skip;
        logic [23:0] prog [13] = '{24'hE40000, 24'h410000, 24'h410001, 24'hE50000,
            24'h020000, 24'h000000, 24'h410002, 24'h310000, 24'h410000, 24'h410003,
            24'hA40000, 24'h410000, 24'h410004};
        for (int i = 0; i < 13; i++) pm.mem[i] = prog[i];
        condTrue = 1;
        run_prog(13);
        condTrue = 0;
        `CHK(issues, 8)
        `CHK(nops, 5)
        `CHK(srcReg_r, 4'h4)
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        #5;
        rst_b = 1;
        t_fields();
        t_table();
        t_freeze();
        t_hold();
        t_twoword();
        t_skip();
        print_verdict();
    end
endmodule
